/* hw/pwc_pkg.sv */
// constants, types and decode helpers for the posted-write error capture bank
package pwc_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int PWC_ADDR_W = 8;
    localparam logic [7:0] PWC_OFF_LOW = 8'h38;
    localparam logic [7:0] PWC_OFF_HIGH = 8'h3C;
    localparam logic [7:0] PWC_OFF_COMPANY = 8'h40;
    localparam logic [7:0] PWC_OFF_STATUS = 8'h60;
    localparam logic [7:0] PWC_OFF_MASK = 8'h64;
    localparam logic [7:0] PWC_WORD_MASK = 8'hFC;

    // ****************************************************************
    // field positions of the high capture word
    // ****************************************************************
    localparam int PWC_OFFHI_LSB = 0;
    localparam int PWC_OFFHI_MSB = 15;
    localparam int PWC_NODE_LSB = 16;
    localparam int PWC_NODE_MSB = 21;
    localparam int PWC_BUS_LSB = 22;
    localparam int PWC_BUS_MSB = 31;

    // ****************************************************************
    // event bits, shared by status and mask
    // ****************************************************************
    localparam int PWC_EV_CAPTURE = 0;
    localparam int PWC_EV_OVERRUN = 1;
    localparam int PWC_EV_W = 2;

    // ****************************************************************
    // reset values and bus answers
    // ****************************************************************
    localparam logic [31:0] PWC_CAPTURE_RST = 32'h0000_0000;
    localparam logic [PWC_EV_W-1:0] PWC_EV_RST = 2'h0;
    localparam logic [31:0] PWC_RDATA_RST = 32'h0000_0000;
    localparam logic [1:0] PWC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PWC_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0]
    {
        PWC_SEL_NONE = 3'h0,
        PWC_SEL_LOW = 3'h1,
        PWC_SEL_HIGH = 3'h2,
        PWC_SEL_COMPANY = 3'h3,
        PWC_SEL_STATUS = 3'h4,
        PWC_SEL_MASK = 3'h5
    } pwc_sel_e;

    typedef enum logic [1:0]
    {
        PWC_WR_IDLE = 2'h0,
        PWC_WR_COLLECT = 2'h1,
        PWC_WR_RESP = 2'h3
    } pwc_wr_e;

    // failed posted write as reported by the receive path
    typedef struct packed {
        logic [9:0] bus;
        logic [5:0] node;
        logic [47:0] offset;
    } pwc_fail_s;

    typedef struct packed {
        logic [31:0] low;
        logic [31:0] high;
    } pwc_capture_s;

    typedef struct packed {
        logic [PWC_EV_W-1:0] status;
        logic [PWC_EV_W-1:0] mask;
    } pwc_irq_s;

    typedef struct packed {
        pwc_wr_e wr_state;
        logic aw_held;
        logic w_held;
        logic [PWC_ADDR_W-1:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pwc_axi_s;

    function automatic pwc_sel_e pwc_decode(input logic [PWC_ADDR_W-1:0] addr);
        pwc_sel_e sel;
        sel = PWC_SEL_NONE;
        case (addr & PWC_WORD_MASK)
            PWC_OFF_LOW: sel = PWC_SEL_LOW;
            PWC_OFF_HIGH: sel = PWC_SEL_HIGH;
            PWC_OFF_COMPANY: sel = PWC_SEL_COMPANY;
            PWC_OFF_STATUS: sel = PWC_SEL_STATUS;
            PWC_OFF_MASK: sel = PWC_SEL_MASK;
            default: sel = PWC_SEL_NONE;
        endcase
        return sel;
    endfunction

endpackage

/* hw/pwc_capture.sv */
// capture registers for the failed posted write
`timescale 1ns/1ps
module pwc_capture
    import pwc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic fail_valid,
    input wire pwc_fail_s fail,
    output pwc_capture_s regs
);

    pwc_capture_s st;
    pwc_capture_s next_st;

    always_comb
    begin
        next_st = st;
        // bus reads never reach here, so only a new failure moves these
        if (fail_valid)
        begin
            next_st.low = fail.offset[31:0];
            next_st.high[PWC_OFFHI_MSB:PWC_OFFHI_LSB] = fail.offset[47:32];
            next_st.high[PWC_NODE_MSB:PWC_NODE_LSB] = fail.node;
            next_st.high[PWC_BUS_MSB:PWC_BUS_LSB] = fail.bus;
        end
    end

    // contents are undefined until a capture; zero is a legal choice
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st <= '{low: PWC_CAPTURE_RST, high: PWC_CAPTURE_RST};
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    assign regs = st;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_fail;
        ce && fail_valid;
    endsequence

    a_capture_low: assert property (s_fail |=> st.low == $past(fail.offset[31:0]))
        else $error("low capture word differs from failed offset");
    a_capture_high: assert property (s_fail |=> st.high[15:0] == $past(fail.offset[47:32]))
        else $error("high capture offset bits differ from failed offset");
    a_capture_source: assert property (s_fail |=> st.high[31:16] == $past({fail.bus, fail.node}))
        else $error("requester identity not captured");
    a_capture_hold: assert property (!(ce && fail_valid) |=> $stable(st))
        else $error("capture words changed without a failure");

endmodule // pwc_capture

/* hw/pwc_irq.sv */
// sticky event status, mask and interrupt line
`timescale 1ns/1ps
module pwc_irq
    import pwc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [PWC_EV_W-1:0] events,
    input wire logic wr_status,
    input wire logic wr_mask,
    input wire logic [PWC_EV_W-1:0] wr_bits,
    output pwc_irq_s regs,
    output logic irq
);

    pwc_irq_s st;
    pwc_irq_s next_st;

    always_comb
    begin
        next_st = st;
        if (wr_status)
        begin
            next_st.status = st.status & ~wr_bits;
        end
        if (wr_mask)
        begin
            next_st.mask = wr_bits;
        end
        // set after clear so a same-cycle event survives the clear
        next_st.status = next_st.status | events;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st <= '{status: PWC_EV_RST, mask: PWC_EV_RST};
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    assign regs = st;
    assign irq = |(st.status & st.mask);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_event_sticky: assert property (ce && (|events) |=> (st.status & $past(events)) == $past(events))
        else $error("event lost against a status clear");

endmodule // pwc_irq

/* hw/pwc_top.sv */
// posted-write error capture bank with an axi4-lite register slave
`timescale 1ns/1ps

module pwc_top
    import pwc_pkg::*;
#(
    parameter logic [31:0] COMPANY_ID = 32'h0000_5A5A // arbitrary value
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic fail_valid,
    input wire pwc_fail_s fail,
    output logic irq,
    input wire logic [PWC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [PWC_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ****************************************************************
    // capture and interrupt units
    // ****************************************************************
    pwc_axi_s st;
    pwc_axi_s next_st;
    pwc_capture_s cap;
    pwc_irq_s ev;
    logic [PWC_EV_W-1:0] events;
    logic wr_status;
    logic wr_mask;
    logic [PWC_EV_W-1:0] wr_bits;

    pwc_capture u_capture
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .fail_valid(fail_valid),
        .fail(fail),
        .regs(cap)
    );

    // overrun: a new failure arrives before software cleared the last one
    always_comb
    begin
        events = '0;
        events[PWC_EV_CAPTURE] = fail_valid;
        events[PWC_EV_OVERRUN] = fail_valid & ev.status[PWC_EV_CAPTURE];
    end

    pwc_irq u_irq
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .events(events),
        .wr_status(wr_status),
        .wr_mask(wr_mask),
        .wr_bits(wr_bits),
        .regs(ev),
        .irq(irq)
    );

    // ****************************************************************
    // axi4-lite handshakes
    // ****************************************************************
    // ready and valid are gated by ce so no handshake completes while frozen
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic have_addr;
    logic have_data;
    logic [PWC_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_fire;
    pwc_sel_e wr_sel;
    pwc_sel_e rd_sel;

    assign s_axi_awready = ce && (st.wr_state != PWC_WR_RESP) && !st.aw_held;
    assign s_axi_wready = ce && (st.wr_state != PWC_WR_RESP) && !st.w_held;
    assign s_axi_bvalid = ce && (st.wr_state == PWC_WR_RESP);
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = ce && !st.rvalid;
    assign s_axi_rvalid = ce && st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign have_addr = st.aw_held || aw_take;
    assign have_data = st.w_held || w_take;
    assign wr_addr = st.aw_held ? st.waddr : s_axi_awaddr;
    assign wr_data = st.w_held ? st.wdata : s_axi_wdata;
    assign wr_strb = st.w_held ? st.wstrb : s_axi_wstrb;
    assign wr_fire = have_addr && have_data && (st.wr_state != PWC_WR_RESP);
    assign wr_sel = pwc_decode(wr_addr);
    assign rd_sel = pwc_decode(s_axi_araddr);

    // only byte lane 0 carries writable bits
    assign wr_status = wr_fire && (wr_sel == PWC_SEL_STATUS) && wr_strb[0];
    assign wr_mask = wr_fire && (wr_sel == PWC_SEL_MASK) && wr_strb[0];
    assign wr_bits = wr_data[PWC_EV_W-1:0];

    // ****************************************************************
    // write and read state
    // ****************************************************************
    always_comb
    begin
        next_st = st;
        if (aw_take)
        begin
            next_st.aw_held = 1'b1;
            next_st.waddr = s_axi_awaddr;
        end
        if (w_take)
        begin
            next_st.w_held = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        case (st.wr_state)
            PWC_WR_IDLE, PWC_WR_COLLECT:
            begin
                if (wr_fire)
                begin
                    // capture and company words ignore writes and answer okay
                    next_st.wr_state = PWC_WR_RESP;
                    next_st.aw_held = 1'b0;
                    next_st.w_held = 1'b0;
                    next_st.bresp = (wr_sel == PWC_SEL_NONE) ? PWC_RESP_SLVERR
                                                             : PWC_RESP_OKAY;
                end
                else if (aw_take || w_take)
                begin
                    next_st.wr_state = PWC_WR_COLLECT;
                end
            end
            PWC_WR_RESP:
            begin
                if (s_axi_bready)
                begin
                    next_st.wr_state = PWC_WR_IDLE;
                end
            end
            default:
            begin
                next_st.wr_state = PWC_WR_IDLE;
            end
        endcase

        if (st.rvalid && s_axi_rready)
        begin
            next_st.rvalid = 1'b0;
        end
        if (ar_take)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp = PWC_RESP_OKAY;
            // reading has no side effect on the captured words
            case (rd_sel)
                PWC_SEL_LOW: next_st.rdata = cap.low;
                PWC_SEL_HIGH: next_st.rdata = cap.high;
                PWC_SEL_COMPANY: next_st.rdata = COMPANY_ID;
                PWC_SEL_STATUS: next_st.rdata = {{(32-PWC_EV_W){1'b0}}, ev.status};
                PWC_SEL_MASK: next_st.rdata = {{(32-PWC_EV_W){1'b0}}, ev.mask};
                default:
                begin
                    next_st.rdata = PWC_RDATA_RST;
                    next_st.rresp = PWC_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st <= '{wr_state: PWC_WR_IDLE, aw_held: 1'b0, w_held: 1'b0,
                    waddr: '0, wdata: PWC_RDATA_RST, wstrb: 4'h0,
                    bresp: PWC_RESP_OKAY, rvalid: 1'b0, rdata: PWC_RDATA_RST,
                    rresp: PWC_RESP_OKAY};
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_rd_take(logic [PWC_ADDR_W-1:0] a);
        ar_take && ((s_axi_araddr & PWC_WORD_MASK) == a);
    endsequence

    sequence s_wr_fire(pwc_sel_e sel);
        ce && wr_fire && (wr_sel == sel);
    endsequence

    a_read_low: assert property (s_rd_take(PWC_OFF_LOW) |=> st.rvalid
        && st.rdata == $past(cap.low) && st.rresp == PWC_RESP_OKAY)
        else $error("low capture read returned wrong data");
    a_read_high: assert property (s_rd_take(PWC_OFF_HIGH) |=> st.rvalid
        && st.rdata == $past(cap.high) && st.rresp == PWC_RESP_OKAY)
        else $error("high capture read returned wrong data");
    a_read_company: assert property (s_rd_take(PWC_OFF_COMPANY) |=> st.rvalid
        && st.rdata == COMPANY_ID && st.rresp == PWC_RESP_OKAY)
        else $error("company word read returned wrong data");
    a_write_company_nop: assert property (s_wr_fire(PWC_SEL_COMPANY) |=>
        st.wr_state == PWC_WR_RESP && st.bresp == PWC_RESP_OKAY && !$past(wr_status)
        && !$past(wr_mask))
        else $error("write to company word had an effect");
    a_write_capture_nop: assert property (ce && wr_fire && !fail_valid
        && (wr_sel == PWC_SEL_LOW || wr_sel == PWC_SEL_HIGH) |=> $stable(cap))
        else $error("software write altered a captured word");
    a_read_keeps: assert property (ar_take && !fail_valid |=> $stable(cap))
        else $error("read altered a captured word");
    a_capture_irq: assert property (ce && fail_valid && !wr_mask
        && ev.mask[PWC_EV_CAPTURE] |=> irq)
        else $error("capture did not raise the interrupt");
    a_unmapped_err: assert property (ar_take && rd_sel == PWC_SEL_NONE |=>
        st.rvalid && st.rresp == PWC_RESP_SLVERR)
        else $error("unmapped read not refused");

    // ****************************************************************
    // bus protocol checks
    // ****************************************************************
    // an answer that is not yet taken must neither vanish nor change
    sequence s_b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence

    sequence s_r_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence

    // the write answer follows the edge at which address and data are both held
    sequence s_write_done;
        ce && wr_fire;
    endsequence

    a_bresp_holds: assert property (s_b_wait |=>
        st.wr_state == PWC_WR_RESP && $stable(st.bresp))
        else $error("write response dropped before it was taken");

    a_rdata_holds: assert property (s_r_wait |=>
        st.rvalid && $stable(st.rdata) && $stable(st.rresp))
        else $error("read data changed before it was taken");

    a_write_answer: assert property (s_write_done |=> st.wr_state == PWC_WR_RESP
        && !st.aw_held && !st.w_held)
        else $error("write not answered after address and data");

    a_unmapped_wr: assert property (s_wr_fire(PWC_SEL_NONE) |=>
        st.bresp == PWC_RESP_SLVERR)
        else $error("unmapped write not refused");

    a_busy_refuse: assert property (st.wr_state == PWC_WR_RESP |->
        !s_axi_awready && !s_axi_wready)
        else $error("write channel accepted while a response is pending");

    a_read_refuse: assert property (st.rvalid |-> !s_axi_arready)
        else $error("read address accepted while read data is pending");

    // a frozen block must not complete any handshake
    a_frozen_quiet: assert property (!ce |-> !s_axi_awready && !s_axi_wready
        && !s_axi_arready && !s_axi_bvalid && !s_axi_rvalid)
        else $error("handshake signal active while clock enable is low");

    a_mask_write: assert property (ce && wr_mask |=> ev.mask == $past(wr_bits))
        else $error("mask write did not land");

    a_status_clear: assert property (ce && wr_status && !(|events) |=>
        (ev.status & $past(wr_bits)) == '0)
        else $error("status bits not cleared by a one");

endmodule // pwc_top

/* verification/pwc_top_bench.sv */
// self-checking bench for the posted-write error capture bank
`timescale 1ns/1ps
module pwc_top_bench
    import pwc_pkg::*;
;
    // ****************************************************************
    // signals and model state
    // ****************************************************************
    localparam logic [31:0] COMPANY = 32'h0000_C3A5; // arbitrary value
    logic aclk;
    logic aresetn;
    logic ce;
    logic fail_valid;
    pwc_fail_s fail;
    logic irq;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int num_errors;
    int compares;
    logic [31:0] exp_low, exp_high;
    logic [1:0] exp_status, exp_mask;
    logic [31:0] rd;
    logic [1:0] rsp;
    logic [7:0] bad_addr [4] = '{8'h00, 8'h44, 8'h68, 8'hFC};

    pwc_top #(.COMPANY_ID(COMPANY)) pwc_top_inst (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .fail_valid(fail_valid), .fail(fail),
        .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready)
    );

    // ****************************************************************
    // clock, watchdog, verdict
    // ****************************************************************
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic report_and_stop();
        if (num_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // generous: the whole sequence needs well under 3000 cycles
    initial
    begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        $display("ERROR %0t watchdog expired", $time);
        report_and_stop();
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        compares++;
        if (seen !== expected)
        begin
            num_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, expected);
        end
    endtask

    // ****************************************************************
    // axi4-lite master
    // ****************************************************************
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done, w_done, b_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        b_done = 1'b0;
        r = 2'h3;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_done)
        begin
            @(posedge aclk);
            if (!aw_done && awready === 1'b1)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
            if (bvalid === 1'b1)
            begin
                b_done = 1'b1;
                r = bresp;
                bready <= 1'b0;
            end
        end
        // the answer may only follow both address and data
        check({31'h0, aw_done & w_done}, 32'h1);
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_done, r_done;
        ar_done = 1'b0;
        r_done = 1'b0;
        d = 32'h0;
        r = 2'h3;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_done)
        begin
            @(posedge aclk);
            if (!ar_done && arready === 1'b1)
            begin
                ar_done = 1'b1;
                arvalid <= 1'b0;
            end
            if (rvalid === 1'b1)
            begin
                r_done = 1'b1;
                d = rdata;
                r = rresp;
                rready <= 1'b0;
            end
        end
        // read data may only follow the taken address
        check({31'h0, ar_done}, 32'h1);
    endtask

    task automatic read_check(input logic [7:0] a, input logic [31:0] expected);
        axi_read(a, rd, rsp);
        check({30'h0, rsp}, {30'h0, PWC_RESP_OKAY});
        check(rd, expected);
    endtask

    // ****************************************************************
    // capture stimulus and register sweep
    // ****************************************************************
    // n back-to-back failures; fail_valid stays high between them
    task automatic capture(input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge aclk);
            fail_valid <= 1'b1;
            fail <= {$urandom, $urandom};
            #1;
            // a frozen block must keep its old captures
            if (ce === 1'b1)
            begin
                exp_low = fail.offset[31:0];
                exp_high = {fail.bus, fail.node, fail.offset[47:32]};
                exp_status[1] = exp_status[1] | exp_status[0];
                exp_status[0] = 1'b1;
            end
        end
        @(posedge aclk);
        fail_valid <= 1'b0;
    endtask

    task automatic sweep();
        for (int k = 0; k < 2; k++)
        begin
            read_check(PWC_OFF_LOW, exp_low);
            read_check(PWC_OFF_HIGH, exp_high);
        end
        read_check(PWC_OFF_STATUS, {30'h0, exp_status});
        read_check(PWC_OFF_MASK, {30'h0, exp_mask});
        check({31'h0, irq}, {31'h0, |(exp_status & exp_mask)});
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        num_errors = 0;
        compares = 0;
        aresetn = 1'b0;
        ce = 1'b1;
        fail_valid = 1'b0;
        fail = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        exp_low = PWC_CAPTURE_RST;
        exp_high = PWC_CAPTURE_RST;
        exp_status = PWC_EV_RST;
        exp_mask = PWC_EV_RST;
        void'($urandom(32'h25bb));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        sweep();
        read_check(PWC_OFF_COMPANY, COMPANY);
        // writes to the read-only words are answered but ignored
        for (int i = 0; i < 3; i++)
        begin
            axi_write(PWC_OFF_LOW + 8'(4 * i), $urandom, rsp);
            check({30'h0, rsp}, {30'h0, PWC_RESP_OKAY});
        end
        read_check(PWC_OFF_COMPANY, COMPANY);
        sweep();
        for (int i = 0; i < 4; i++)
        begin
            axi_write(bad_addr[i], $urandom, rsp);
            check({30'h0, rsp}, {30'h0, PWC_RESP_SLVERR});
            axi_read(bad_addr[i], rd, rsp);
            check({30'h0, rsp}, {30'h0, PWC_RESP_SLVERR});
            check(rd, PWC_RDATA_RST);
        end
        for (int it = 0; it < 30; it++)
        begin
            exp_mask = 2'($urandom);
            axi_write(PWC_OFF_MASK, {30'h0, exp_mask}, rsp);
            check({30'h0, rsp}, {30'h0, PWC_RESP_OKAY});
            if ($urandom % 4 != 0)
                capture(1 + $urandom % 3);
            sweep();
            rd = {30'h0, 2'($urandom)};
            axi_write(PWC_OFF_STATUS, rd, rsp);
            check({30'h0, rsp}, {30'h0, PWC_RESP_OKAY});
            exp_status = exp_status & ~rd[1:0];
            sweep();
        end
        // clock enable low: a failure pulse must leave the captures alone
        @(posedge aclk);
        ce <= 1'b0;
        capture(1);
        @(posedge aclk);
        ce <= 1'b1;
        sweep();
        capture(2);
        sweep();
        report_and_stop();
    end
endmodule // pwc_top_bench
